// [hw/pfsm_top.sv]
/*
  Port A function select multiplexer for the six-pin package, with port C
  single-bit selection, GPIO edge interrupts and an APB register slave.
  Assumes pins and peripherals synchronous to clk_i; analog users take the
  analog enables as switch controls.
*/
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [RULE1] Select code applies only when alternate enabled
// [RULE2] Port C uses set one bit only
// [RULE3] A0: timer0 input or complemented timer0 output
// [RULE4] A2: driver enable, reset in, timer1 out
// [RULE5] A3: CTS, comparator out, timer1 in, analog
// [RULE6] A4: receive data or analog
// [RULE7] A5: transmit data or complemented timer1 output
// [RULE8] A5 code 11 gives analog functions
// [RULE9] Analog code hands pin to analog users
// [RULE10] Some pins interrupt on chosen single edge
// [RULE11] Other pins interrupt on both edges
// [RULE12] Port C2 reference only in mid package
// [RULE13] Alternate function overrides data direction
// [RULE14] A1: timer0 out, external clock, analog
module pfsm_top #(
  parameter pfsm_pkg::pfsm_variant_t VARIANT = pfsm_pkg::PFSM_PKG_SMALL
) (
  // Clock, reset, enable
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic                        clk_en_i,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pfsm_pkg::PFSM_AW-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Port A pins
  input  wire logic [pfsm_pkg::PFSM_PINS-1:0] pin_in_i,
  output logic      [pfsm_pkg::PFSM_PINS-1:0] pin_out_o,
  output logic      [pfsm_pkg::PFSM_PINS-1:0] pin_oe_o,
  output logic      [pfsm_pkg::PFSM_PINS-1:0] pin_analog_o,
  // Peripheral outputs to route onto pins
  input  wire logic                        timer0_output_i,
  input  wire logic                        timer1_output_i,
  input  wire logic                        uart_driver_enable_i,
  input  wire logic                        uart_transmit_data_i,
  input  wire logic                        comparator_output_i,
  // Peripheral inputs taken from pins
  output logic                             timer0_input_o,
  output logic                             external_clock_input_o,
  output logic                             ext_reset_n_o,
  output logic                             uart_clear_to_send_o,
  output logic                             timer1_input_o,
  output logic                             uart_receive_data_o,
  // Port C selection
  output logic      [7:0]                  portc_alt_sel_o,
  output logic                             portc2_vref_o,
  // Interrupt
  output logic                             irq_o
);
  import pfsm_pkg::*;

  // ==========================================================================
  // APB decode
  // ==========================================================================
  logic [5:0] afen_q, sel1_q, sel2_q, dir_q, out_q, mask_q;
  logic [3:0] edge_q;
  logic [7:0] pcsel_q;
  logic       wr_en;
  logic       mapped;
  logic [5:0] stat;
  logic [5:0] clr;

  function automatic logic hit(input logic [PFSM_AW-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs[PFSM_AW-1:0]);
  endfunction

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite && clk_en_i;
  always_comb begin
    mapped = hit(paddr, PFSM_OFS_AFEN) || hit(paddr, PFSM_OFS_SEL1) ||
             hit(paddr, PFSM_OFS_SEL2) || hit(paddr, PFSM_OFS_DIR) ||
             hit(paddr, PFSM_OFS_OUT)  || hit(paddr, PFSM_OFS_IN) ||
             hit(paddr, PFSM_OFS_EDGE) || hit(paddr, PFSM_OFS_STAT) ||
             hit(paddr, PFSM_OFS_MASK) || hit(paddr, PFSM_OFS_PCSEL);
  end
  assign pslverr = psel && penable && !mapped;

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      afen_q  <= PFSM_RST_AFEN;
      sel1_q  <= PFSM_RST_SEL;
      sel2_q  <= PFSM_RST_SEL;
      dir_q   <= PFSM_RST_DIR;
      out_q   <= PFSM_RST_OUT;
      edge_q  <= PFSM_RST_EDGE;
      mask_q  <= PFSM_RST_AFEN;
      pcsel_q <= PFSM_RST_PCSEL;
    end else if (wr_en) begin
      if (hit(paddr, PFSM_OFS_AFEN))  afen_q  <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_SEL1))  sel1_q  <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_SEL2))  sel2_q  <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_DIR))   dir_q   <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_OUT))   out_q   <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_EDGE))  edge_q  <= pwdata[3:0];
      if (hit(paddr, PFSM_OFS_MASK))  mask_q  <= pwdata[5:0];
      if (hit(paddr, PFSM_OFS_PCSEL)) pcsel_q <= pwdata[7:0];
    end
  end

  assign clr = (wr_en && hit(paddr, PFSM_OFS_STAT)) ? pwdata[5:0] : '0;

  // Read data registered so it is stable in the access phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata <= PFSM_RD_ZERO;
    end else if (clk_en_i) begin
      prdata <= PFSM_RD_ZERO;
      if (psel && !penable) begin
        if (hit(paddr, PFSM_OFS_AFEN))  prdata[5:0] <= afen_q;
        if (hit(paddr, PFSM_OFS_SEL1))  prdata[5:0] <= sel1_q;
        if (hit(paddr, PFSM_OFS_SEL2))  prdata[5:0] <= sel2_q;
        if (hit(paddr, PFSM_OFS_DIR))   prdata[5:0] <= dir_q;
        if (hit(paddr, PFSM_OFS_OUT))   prdata[5:0] <= out_q;
        if (hit(paddr, PFSM_OFS_IN))    prdata[5:0] <= pin_in_i;
        if (hit(paddr, PFSM_OFS_EDGE))  prdata[3:0] <= edge_q;
        if (hit(paddr, PFSM_OFS_STAT))  prdata[5:0] <= stat;
        if (hit(paddr, PFSM_OFS_MASK))  prdata[5:0] <= mask_q;
        if (hit(paddr, PFSM_OFS_PCSEL)) prdata[7:0] <= pcsel_q;
      end else if (psel && penable) begin
        prdata <= prdata;
      end
    end
  end

  // ==========================================================================
  // Routing
  // ==========================================================================
  logic [5:0] pin_d, oe_d, ana_d, digin_d;

  pfsm_route u_route (
    .afen_i               (afen_q),
    .sel1_i               (sel1_q),
    .sel2_i               (sel2_q),
    .dir_i                (dir_q),
    .gpio_out_i           (out_q),
    .timer0_output_i      (timer0_output_i),
    .timer1_output_i      (timer1_output_i),
    .uart_driver_enable_i (uart_driver_enable_i),
    .uart_transmit_data_i (uart_transmit_data_i),
    .comparator_output_i  (comparator_output_i),
    .pin_d_o              (pin_d),
    .pin_oe_d_o           (oe_d),
    .analog_d_o           (ana_d),
    .digin_d_o            (digin_d)
  );

  // Pin drive registered; analog pins never driven digitally
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_out_o    <= '0;
      pin_oe_o     <= '0;
      pin_analog_o <= '0;
    end else if (clk_en_i) begin
      pin_out_o    <= pin_d;
      pin_oe_o     <= oe_d & ~ana_d; // [RULE9]
      pin_analog_o <= ana_d;
    end
  end

  // Peripheral inputs: idle level when the pin is not routed there
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer0_input_o         <= 1'b0;
      external_clock_input_o <= 1'b0;
      ext_reset_n_o          <= 1'b1;
      uart_clear_to_send_o   <= 1'b0;
      timer1_input_o         <= 1'b0;
      uart_receive_data_o    <= 1'b1;
    end else if (clk_en_i) begin
      timer0_input_o         <= digin_d[PFSM_A0] & pin_in_i[PFSM_A0]; // [RULE3]
      external_clock_input_o <= digin_d[PFSM_A1] & pin_in_i[PFSM_A1]; // [RULE14]
      ext_reset_n_o          <= ~digin_d[PFSM_A2] | pin_in_i[PFSM_A2]; // [RULE4]
      uart_clear_to_send_o   <= digin_d[PFSM_A3] && !sel1_q[PFSM_A3] &&
                                pin_in_i[PFSM_A3]; // [RULE5]
      timer1_input_o         <= digin_d[PFSM_A3] && sel1_q[PFSM_A3] &&
                                pin_in_i[PFSM_A3]; // [RULE5]
      uart_receive_data_o    <= ~digin_d[PFSM_A4] | pin_in_i[PFSM_A4]; // [RULE6]
    end
  end

  // ==========================================================================
  // Port C: one select bit per pin, set two has no say
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      portc_alt_sel_o <= PFSM_RST_PCSEL;
      portc2_vref_o   <= 1'b0;
    end else if (clk_en_i) begin
      portc_alt_sel_o <= pcsel_q; // [RULE2]
      portc2_vref_o   <= pcsel_q[PFSM_C2] && (VARIANT == PFSM_PKG_MID); // [RULE12]
    end
  end

  // ==========================================================================
  // Edge interrupts
  // ==========================================================================
  pfsm_edge_irq #(
    .N    (PFSM_PINS),
    .NSEL (PFSM_EDGE_PINS)
  ) u_irq (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .en_i       (clk_en_i),
    .pin_i      (pin_in_i),
    .rise_sel_i (edge_q),
    .clear_i    (clr),
    .mask_i     (mask_q),
    .status_o   (stat),
    .irq_o      (irq_o)
  );

endmodule : pfsm_top
`default_nettype wire

// [include/pfsm_pkg.sv]
/*
  Constants for the port A function select multiplexer: APB register map,
  reset values, select codes and pin indices.
  Assumes a 32-bit APB bus with byte addresses and word-aligned registers.
*/
package pfsm_pkg;

  localparam int          PFSM_PINS        = 6;
  localparam int          PFSM_EDGE_PINS   = 4;
  localparam int          PFSM_AW          = 8;

  // Register byte offsets
  localparam logic [7:0]  PFSM_OFS_AFEN    = 8'h00;
  localparam logic [7:0]  PFSM_OFS_SEL1    = 8'h04;
  localparam logic [7:0]  PFSM_OFS_SEL2    = 8'h08;
  localparam logic [7:0]  PFSM_OFS_DIR     = 8'h0C;
  localparam logic [7:0]  PFSM_OFS_OUT     = 8'h10;
  localparam logic [7:0]  PFSM_OFS_IN      = 8'h14;
  localparam logic [7:0]  PFSM_OFS_EDGE    = 8'h18;
  localparam logic [7:0]  PFSM_OFS_STAT    = 8'h1C;
  localparam logic [7:0]  PFSM_OFS_MASK    = 8'h20;
  localparam logic [7:0]  PFSM_OFS_PCSEL   = 8'h24;

  // Reset values
  localparam logic [5:0]  PFSM_RST_AFEN    = 6'h00;
  localparam logic [5:0]  PFSM_RST_SEL     = 6'h00;
  localparam logic [5:0]  PFSM_RST_DIR     = 6'h3F;
  localparam logic [5:0]  PFSM_RST_OUT     = 6'h00;
  localparam logic [3:0]  PFSM_RST_EDGE    = 4'h0;
  localparam logic [7:0]  PFSM_RST_PCSEL   = 8'h00;
  localparam logic [31:0] PFSM_RD_ZERO     = 32'h0000_0000;

  // Two-bit codes: {set one bit, set two bit}
  localparam logic [1:0]  PFSM_CODE_00     = 2'h0;
  localparam logic [1:0]  PFSM_CODE_01     = 2'h1;
  localparam logic [1:0]  PFSM_CODE_10     = 2'h2;
  localparam logic [1:0]  PFSM_CODE_11     = 2'h3;

  // Pin indices
  localparam int          PFSM_A0 = 0;
  localparam int          PFSM_A1 = 1;
  localparam int          PFSM_A2 = 2;
  localparam int          PFSM_A3 = 3;
  localparam int          PFSM_A4 = 4;
  localparam int          PFSM_A5 = 5;
  localparam int          PFSM_C2 = 2;

  // Package variants
  typedef enum logic [1:0] {
    PFSM_PKG_SMALL = 2'h0,
    PFSM_PKG_MID   = 2'h1,
    PFSM_PKG_LARGE = 2'h2
  } pfsm_variant_t;

endpackage : pfsm_pkg

// [hw/pfsm_edge_irq.sv]
/*
  Pin edge interrupt detector with sticky status, write-one-to-clear and mask.
  Assumes pin inputs synchronous to clk_i; set wins over a clear.
*/
`timescale 1ns/1ns
`default_nettype none
module pfsm_edge_irq #(
  parameter int N      = 6,
  parameter int NSEL   = 4
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          en_i,
  // Pin levels and edge configuration
  input  wire logic [N-1:0]  pin_i,
  input  wire logic [NSEL-1:0] rise_sel_i,
  // Software clear and mask
  input  wire logic [N-1:0]  clear_i,
  input  wire logic [N-1:0]  mask_i,
  // Status and request
  output logic      [N-1:0]  status_o,
  output logic               irq_o
);
  logic [N-1:0] prev_q;
  logic [N-1:0] prime_q;
  logic [N-1:0] event_d;

  // Reference level taken after reset, so a pin held high is not an edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q  <= '0;
      prime_q <= '0;
    end else if (en_i) begin
      prev_q  <= pin_i;
      prime_q <= '1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_evt
      if (g < NSEL) begin : g_sel
        // One driver per bit keeps the generate free of shared writers
        assign event_d[g] = prime_q[g] &&
                            (rise_sel_i[g] ? (pin_i[g] && !prev_q[g])
                                           : (!pin_i[g] && prev_q[g])); // [RULE10]
      end else begin : g_any
        assign event_d[g] = prime_q[g] && (pin_i[g] ^ prev_q[g]); // [RULE11]
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_o <= '0;
    end else if (en_i) begin
      status_o <= (status_o & ~clear_i) | event_d;
    end
  end

  assign irq_o = |(status_o & mask_i);

endmodule : pfsm_edge_irq
`default_nettype wire

// [hw/pfsm_route.sv]
/*
  Combinational route table: per-pin select code to peripheral connection.
  Assumes the caller registers what leaves the block.
*/
`timescale 1ns/1ns
`default_nettype none
module pfsm_route (
  // Configuration
  input  wire logic [5:0] afen_i,
  input  wire logic [5:0] sel1_i,
  input  wire logic [5:0] sel2_i,
  input  wire logic [5:0] dir_i,
  input  wire logic [5:0] gpio_out_i,
  // Peripheral outputs towards pins
  input  wire logic       timer0_output_i,
  input  wire logic       timer1_output_i,
  input  wire logic       uart_driver_enable_i,
  input  wire logic       uart_transmit_data_i,
  input  wire logic       comparator_output_i,
  // Pin drive
  output logic      [5:0] pin_d_o,
  output logic      [5:0] pin_oe_d_o,
  output logic      [5:0] analog_d_o,
  output logic      [5:0] digin_d_o
);
  import pfsm_pkg::*;

  function automatic logic [1:0] code_of(input logic [5:0] s1, input logic [5:0] s2,
                                         input int n);
    code_of = {s1[n], s2[n]};
  endfunction

  logic [1:0] c0, c1, c2, c3, c4, c5;

  always_comb begin
    c0 = code_of(sel1_i, sel2_i, PFSM_A0);
    c1 = code_of(sel1_i, sel2_i, PFSM_A1);
    c2 = code_of(sel1_i, sel2_i, PFSM_A2);
    c3 = code_of(sel1_i, sel2_i, PFSM_A3);
    c4 = code_of(sel1_i, sel2_i, PFSM_A4);
    c5 = code_of(sel1_i, sel2_i, PFSM_A5);
    // GPIO defaults; reserved codes fall back to input, no drive
    pin_d_o    = gpio_out_i;
    pin_oe_d_o = ~dir_i;
    analog_d_o = '0;
    digin_d_o  = '0;
    // Alternate function overrides the direction bit
    for (int i = 0; i < PFSM_PINS; i++) begin
      if (afen_i[i]) begin // [RULE1] [RULE13]
        pin_oe_d_o[i] = 1'b0;
        pin_d_o[i]    = 1'b0;
      end
    end
    if (afen_i[PFSM_A0]) begin // [RULE3]
      case (c0)
        PFSM_CODE_00: digin_d_o[PFSM_A0] = 1'b1;
        PFSM_CODE_11: begin
          pin_d_o[PFSM_A0]    = ~timer0_output_i;
          pin_oe_d_o[PFSM_A0] = 1'b1;
        end
        default: ;
      endcase
    end
    if (afen_i[PFSM_A1]) begin // [RULE14]
      case (c1)
        PFSM_CODE_00: begin
          pin_d_o[PFSM_A1]    = timer0_output_i;
          pin_oe_d_o[PFSM_A1] = 1'b1;
        end
        PFSM_CODE_10: digin_d_o[PFSM_A1] = 1'b1;
        PFSM_CODE_11: analog_d_o[PFSM_A1] = 1'b1; // [RULE9]
        default: ;
      endcase
    end
    if (afen_i[PFSM_A2]) begin // [RULE4]
      case (c2)
        PFSM_CODE_00: begin
          pin_d_o[PFSM_A2]    = uart_driver_enable_i;
          pin_oe_d_o[PFSM_A2] = 1'b1;
        end
        PFSM_CODE_01: digin_d_o[PFSM_A2] = 1'b1;
        PFSM_CODE_10: begin
          pin_d_o[PFSM_A2]    = timer1_output_i;
          pin_oe_d_o[PFSM_A2] = 1'b1;
        end
        default: ;
      endcase
    end
    if (afen_i[PFSM_A3]) begin // [RULE5]
      case (c3)
        PFSM_CODE_00: digin_d_o[PFSM_A3] = 1'b1;
        PFSM_CODE_01: begin
          pin_d_o[PFSM_A3]    = comparator_output_i;
          pin_oe_d_o[PFSM_A3] = 1'b1;
        end
        PFSM_CODE_10: digin_d_o[PFSM_A3] = 1'b1;
        PFSM_CODE_11: analog_d_o[PFSM_A3] = 1'b1; // [RULE9]
        default: ;
      endcase
    end
    if (afen_i[PFSM_A4]) begin // [RULE6]
      case (c4)
        PFSM_CODE_00: digin_d_o[PFSM_A4] = 1'b1;
        PFSM_CODE_11: analog_d_o[PFSM_A4] = 1'b1; // [RULE9]
        default: ;
      endcase
    end
    if (afen_i[PFSM_A5]) begin // [RULE7]
      case (c5)
        PFSM_CODE_00: begin
          pin_d_o[PFSM_A5]    = uart_transmit_data_i;
          pin_oe_d_o[PFSM_A5] = 1'b1;
        end
        PFSM_CODE_01: begin
          pin_d_o[PFSM_A5]    = ~timer1_output_i;
          pin_oe_d_o[PFSM_A5] = 1'b1;
        end
        PFSM_CODE_11: analog_d_o[PFSM_A5] = 1'b1; // [RULE8] [RULE9]
        default: ;
      endcase
    end
  end

endmodule : pfsm_route
`default_nettype wire

// [dv/pfsm_checker.sv]
/*
  Bound assertions for pfsm_top: APB answer, interrupt clearing, analog hand-over.
  Assumes one clock domain and a single APB master on the top's ports.
*/
`timescale 1ns/1ns
`default_nettype none
module pfsm_checker #(
  parameter pfsm_pkg::pfsm_variant_t VARIANT = pfsm_pkg::PFSM_PKG_SMALL
) (
  // Clock, reset, enable
  input  wire logic                             clk_i,
  input  wire logic                             rst_n_i,
  input  wire logic                             clk_en_i,
  // APB
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [pfsm_pkg::PFSM_AW-1:0]     paddr,
  input  wire logic [31:0]                      pwdata,
  input  wire logic [31:0]                      prdata,
  input  wire logic                             pready,
  input  wire logic                             pslverr,
  // Pins and flags
  input  wire logic [pfsm_pkg::PFSM_PINS-1:0]   pin_in_i,
  input  wire logic [pfsm_pkg::PFSM_PINS-1:0]   pin_oe_o,
  input  wire logic [pfsm_pkg::PFSM_PINS-1:0]   pin_analog_o,
  input  wire logic                             portc2_vref_o,
  input  wire logic                             irq_o
);
  import pfsm_pkg::*;
  logic acc;
  logic wr_ok;
  assign acc   = psel && penable;
  assign wr_ok = acc && pwrite && clk_en_i;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Bus answer
  a_pready_high: assert property (pready)
    else $error("pready dropped");
  a_err_unmapped: assert property (acc && paddr > PFSM_OFS_PCSEL |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && paddr <= PFSM_OFS_PCSEL && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access phase");

  // ==========================================================
  // Pins and interrupts
  a_no_digital_analog: assert property ((pin_oe_o & pin_analog_o) == 6'h00)
    else $error("pin driven while handed to analog");
  a_vref_variant: assert property (VARIANT != PFSM_PKG_MID |-> !portc2_vref_o)
    else $error("reference offered on wrong variant");
  // Stable pins mean no new event can win over the clear
  a_stat_clear_irq: assert property (wr_ok && paddr == PFSM_OFS_STAT && pwdata[5:0] == 6'h3F &&
    $stable(pin_in_i) |=> !irq_o)
    else $error("interrupt stays after clear");
  a_mask_zero_irq: assert property (wr_ok && paddr == PFSM_OFS_MASK && pwdata[5:0] == 6'h00
    |=> !irq_o [*2])
    else $error("interrupt through zero mask");
  a_afen_off_analog: assert property (wr_ok && paddr == PFSM_OFS_AFEN && pwdata[5:0] == 6'h00
    |-> ##2 pin_analog_o == 6'h00)
    else $error("analog kept without alternate enable");
endmodule : pfsm_checker

bind pfsm_top pfsm_checker #(.VARIANT(VARIANT)) i_pfsm_checker (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pin_in_i(pin_in_i), .pin_oe_o(pin_oe_o), .pin_analog_o(pin_analog_o),
  .portc2_vref_o(portc2_vref_o), .irq_o(irq_o)
);
`default_nettype wire

// [dv/pfsm_periph_model.sv]
/*
  Behavioural stand-in for the on-chip peripherals feeding port A.
  Assumes the bench requests output levels on pat_i.
*/
`timescale 1ns/1ns
`default_nettype none
module pfsm_periph_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Requested levels {cmp, txd, de, t1, t0}
  input  wire logic [4:0] pat_i,
  // Peripheral output levels
  output logic            timer0_output_o,
  output logic            timer1_output_o,
  output logic            uart_driver_enable_o,
  output logic            uart_transmit_data_o,
  output logic            comparator_output_o
);
  logic [4:0] lvl_q;
  // Peripherals launch on the clock, so levels move just after an edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lvl_q <= 5'h00;
    end else begin
      lvl_q <= pat_i;
    end
  end
  assign timer0_output_o      = lvl_q[0];
  assign timer1_output_o      = lvl_q[1];
  assign uart_driver_enable_o = lvl_q[2];
  assign uart_transmit_data_o = lvl_q[3];
  assign comparator_output_o  = lvl_q[4];
endmodule : pfsm_periph_model
`default_nettype wire

// [dv/pfsm_top_tb.sv]
/*
  Self-checking bench for pfsm_top: route table, GPIO, registers, interrupts.
  Assumes pfsm_pkg, the design, the checker and the peripheral model compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module pfsm_top_tb;
  import pfsm_pkg::*;
  // ==========================================================
  // Route table, pin-major, code 00..11
  // 0 none, 1-7 drive t0 t1 de tx cmp ~t0 ~t1, 8-13 feed t0 clk rst t1 cts rx, 14 analog
  localparam int ROUTE [24] = '{8, 0, 0, 6, 1, 0, 9, 14, 3, 10, 2, 0,
                                12, 5, 11, 14, 13, 0, 0, 14, 4, 7, 0, 14};
  logic        clk_i, rst_n_i, clk_en_i, psel, penable, pwrite, pready, pslverr, irq_o;
  logic        t0_out, t1_out, de_out, tx_out, cmp_out, e;
  logic        t0_in, clk_in, rst_in, cts_in, t1_in, rx_in, vref;
  logic [7:0]  paddr, pc_sel;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0]  pin_in_i, pin_out_o, pin_oe_o, pin_analog_o, ins;
  logic [4:0]  pat;
  int          error_cnt = 0, samples_checked = 0;
  assign ins = {rx_in, cts_in, t1_in, rst_in, clk_in, t0_in};

  pfsm_periph_model i_pfsm_periph_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .pat_i(pat),
    .timer0_output_o(t0_out), .timer1_output_o(t1_out), .uart_driver_enable_o(de_out),
    .uart_transmit_data_o(tx_out), .comparator_output_o(cmp_out));
  pfsm_top #(.VARIANT(PFSM_PKG_SMALL)) i_pfsm_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin_analog_o(pin_analog_o), .timer0_output_i(t0_out), .timer1_output_i(t1_out),
    .uart_driver_enable_i(de_out), .uart_transmit_data_i(tx_out),
    .comparator_output_i(cmp_out), .timer0_input_o(t0_in), .external_clock_input_o(clk_in),
    .ext_reset_n_o(rst_in), .uart_clear_to_send_o(cts_in), .timer1_input_o(t1_in),
    .uart_receive_data_o(rx_in), .portc_alt_sel_o(pc_sel), .portc2_vref_o(vref),
    .irq_o(irq_o));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Answer taken at the edge itself, before the slave's updates land
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int   n;
    logic rdy;
    @(posedge clk_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      rdy = pready;
      rd  = prdata;
      e   = pslverr;
      n++;
    end while (rdy !== 1'b1 && n < 16);
    if (rdy !== 1'b1) begin
      error_cnt++;
      print_verdict();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic settle();
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [5:0] e_oe, e_out, e_an, e_in;
    logic [6:0] dv;
    logic [1:0] cd;
    logic       lv;
    int         k, pn;
    {psel, penable, pwrite, paddr, pwdata, pin_in_i, pat} = '0;
    rst_n_i = 1'b0;
    clk_en_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 10; i++) rdchk(8'(4 * i), i == 3 ? 32'(PFSM_RST_DIR) : 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk(e, 32'h1);
    chk(rd, 32'h0);
    wr(8'h28, 32'h3F);
    wr(PFSM_OFS_IN, 32'h3F);
    rdchk(PFSM_OFS_IN, 32'h0);
    rdchk(PFSM_OFS_AFEN, 32'h0);
    wr(PFSM_OFS_PCSEL, 32'hFFFF_FFFF);
    rdchk(PFSM_OFS_PCSEL, 32'h0000_00FF);
    for (int r = 0; r < 48; r++) begin
      k  = ROUTE[r / 2];
      pn = r / 8;
      cd = 2'(r / 2);
      lv = r[0];
      wr(PFSM_OFS_SEL1, 32'(cd[1]) << pn);
      pat <= lv ? 5'h16 : 5'h09;
      pin_in_i <= lv ? 6'h01 << pn : ~(6'h01 << pn);
      wr(PFSM_OFS_SEL2, 32'(cd[0]) << pn);
      wr(PFSM_OFS_AFEN, 32'h1 << pn);
      settle();
      dv = {~pat[1], ~pat[0], pat};
      e_oe = 6'h00;
      e_out = 6'h00;
      e_an = 6'h00;
      e_in = 6'h24;
      if (k >= 1 && k <= 7) begin
        e_oe[pn] = 1'b1;
        e_out[pn] = dv[k - 1];
      end
      if (k >= 8 && k <= 13) e_in[k - 8] = lv;
      if (k == 14) e_an[pn] = 1'b1;
      chk(pin_oe_o, e_oe);
      chk(pin_out_o & pin_oe_o, e_out);
      chk(pin_analog_o, e_an);
      chk(ins, e_in);
    end
    wr(PFSM_OFS_DIR, 32'h0);
    wr(PFSM_OFS_OUT, 32'h2A);
    wr(PFSM_OFS_SEL1, 32'h3F);
    wr(PFSM_OFS_SEL2, 32'h3F);
    wr(PFSM_OFS_AFEN, 32'h0);
    settle();
    chk(pin_oe_o, 6'h3F);
    chk(pin_out_o, 6'h2A);
    chk(pin_analog_o, 6'h00);
    chk(ins, 6'h24);
    wr(PFSM_OFS_SEL1, 32'h0);
    wr(PFSM_OFS_SEL2, 32'h0);
    wr(PFSM_OFS_AFEN, 32'h1);
    clk_en_i <= 1'b0;
    wr(PFSM_OFS_AFEN, 32'h3F);
    clk_en_i <= 1'b1;
    settle();
    chk(pin_oe_o, 6'h3E);
    rdchk(PFSM_OFS_AFEN, 32'h1);
    wr(PFSM_OFS_PCSEL, 32'hA5);
    wr(PFSM_OFS_SEL2, 32'h3F);
    settle();
    chk(pc_sel, 8'hA5);
    chk(vref, 1'b0);
    // Falling edges on pins 1 and 3, rising on 0 and 2
    wr(PFSM_OFS_EDGE, 32'h5);
    pin_in_i <= 6'h00;
    wr(PFSM_OFS_MASK, 32'h3F);
    wr(PFSM_OFS_STAT, 32'h3F);
    settle();
    chk(irq_o, 1'b0);
    rdchk(PFSM_OFS_STAT, 32'h0);
    pin_in_i <= 6'h3F;
    settle();
    chk(irq_o, 1'b1);
    rdchk(PFSM_OFS_STAT, 32'h35);
    wr(PFSM_OFS_STAT, 32'h3F);
    pin_in_i <= 6'h00;
    settle();
    rdchk(PFSM_OFS_STAT, 32'h3A);
    wr(PFSM_OFS_MASK, 32'h4);
    settle();
    chk(irq_o, 1'b0);
    wr(PFSM_OFS_MASK, 32'h8);
    settle();
    chk(irq_o, 1'b1);
    wr(PFSM_OFS_MASK, 32'h0);
    settle();
    chk(irq_o, 1'b0);
    wr(PFSM_OFS_MASK, 32'h8);
    wr(PFSM_OFS_STAT, 32'h3F);
    settle();
    chk(irq_o, 1'b0);
    wr(PFSM_OFS_AFEN, 32'h3F);
    rst_n_i <= 1'b0;
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({rst_in, rx_in, irq_o}, 3'h6);
    chk(pin_oe_o, 6'h00);
    rdchk(PFSM_OFS_AFEN, 32'h0);
    rdchk(PFSM_OFS_DIR, 32'(PFSM_RST_DIR));
    print_verdict();
  end
endmodule : pfsm_top_tb
`default_nettype wire
